// ---- hdl/pbp_pkg.sv ----
package pbp_pkg;
   // Port operating modes.
   typedef enum logic [1:0] {
      PBP_MODE_BLOCK    = 2'h0,
      PBP_MODE_DOWNLOAD = 2'h1,
      PBP_MODE_OUTPUT   = 2'h2
   } pbp_mode_e;

   localparam int unsigned CLK_HZ          = 10000000;
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned BLOCK_MUSIC     = 30;
   localparam int unsigned BLOCK_SPEECH    = 10;
   // Core clock period multiples used in block mode.
   localparam int unsigned ACK_CLM         = 5;
   localparam int unsigned EOB_CLM         = 150;
   // Download mode re-arm time in ns (least 0.4 us).
   localparam int unsigned REARM_NS        = 400;
   localparam int unsigned REARM_CYC       =
      ((REARM_NS * (CLK_HZ / 1000000)) + 999) / 1000;
   localparam int unsigned CNT_W           = 16;
endpackage

// ---- hdl/pbp_if.sv ----
`timescale 1ns/1ps
interface pbp_if;
   logic       host_request;
   logic       byte_strobe_n;
   logic       ready_to_receive_n;
   logic       ready_to_send_n;
   logic       end_of_block_n;
   logic [7:0] dev_data_out;
   logic       dev_data_oe;
   logic [7:0] host_data_out;
   logic       host_data_oe;
   wire  [7:0] parallel_data = dev_data_oe  ? dev_data_out :
                               host_data_oe ? host_data_out : 8'h00;

   modport dev  (input  host_request, byte_strobe_n, parallel_data,
                 output ready_to_receive_n, ready_to_send_n, end_of_block_n,
                        dev_data_out, dev_data_oe);
   modport host (output host_request, byte_strobe_n, host_data_out, host_data_oe,
                 input  ready_to_receive_n, ready_to_send_n, end_of_block_n,
                        parallel_data);
endinterface

// ---- hdl/pbp_device.sv ----
`timescale 1ns/1ps
// Contract
// - Host sends only after end_of_block_n high.
// - Host raises host_request per block word.
// - Device samples data, acknowledges with ready_to_receive_n.
// - Host drops request after acknowledge ends.
// - Block end drives end_of_block_n low.
// - Block size 30 music, 10 speech.
// - Download mode keeps host_request low.
// - ready_to_receive_n low until one byte written.
// - Host writes byte with one strobe pulse.
// - Capture on strobe fall, release on rise.
// - Device re-arms each following download byte.
// - Output mode device drives data bytes.
// - Output mode keeps host_request high.
// - ready_to_send_n low while byte waits.
// - Drive on strobe fall, release on rise.
module pbp_device
   import pbp_pkg::*;
#(
   parameter int unsigned CLM_DIV = 1
) (
   // Clock and reset.
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   // Link.
   pbp_if.dev                     link,
   // User side.
   input  wire pbp_mode_e         mode_i,
   input  wire logic              speech_i,
   output logic [DATA_W-1:0]      rx_data_o,
   output logic                   rx_valid_o,
   output logic                   rx_last_o,
   input  wire logic              rx_ready_i,
   input  wire logic [DATA_W-1:0] tx_data_i,
   input  wire logic              tx_valid_i,
   output logic                   tx_ready_o
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ACK  = 6'h02,
      ST_WAIT = 6'h04,
      ST_EOB  = 6'h08,
      ST_ARM  = 6'h10,
      ST_OUT  = 6'h20
   } pbp_state_e;

   pbp_state_e        state_r;
   logic [CNT_W-1:0]  cnt_r;
   logic [5:0]        words_r;
   logic              req_q_r;
   logic              req_pend_r;
   logic              strb_q_r;
   logic              rtr_n_r;
   logic              rts_n_r;
   logic              eob_n_r;
   logic [DATA_W-1:0] out_r;
   logic              out_full_r;
   logic              oe_r;
   logic [CNT_W-1:0]  clm_cnt_r;
   logic              clm_tick;
   logic              req_rise;
   logic              strb_fall;
   logic              strb_rise;
   logic [5:0]        blk_len;

   // Core clock tick divider; block delays count these ticks.
   assign clm_tick = (clm_cnt_r == CNT_W'(CLM_DIV - 1));
   always_ff @(posedge clk_i) begin
      if (reset_i || clm_tick) begin
         clm_cnt_r <= '0;
      end else begin
         clm_cnt_r <= clm_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         req_q_r  <= 1'b0;
         strb_q_r <= 1'b1;
      end else begin
         req_q_r  <= link.host_request;
         strb_q_r <= link.byte_strobe_n;
      end
   end
   assign req_rise  = link.host_request & ~req_q_r;
   assign strb_fall = ~link.byte_strobe_n & strb_q_r;
   assign strb_rise = link.byte_strobe_n & ~strb_q_r;
   assign blk_len   = speech_i ? 6'(BLOCK_SPEECH) : 6'(BLOCK_MUSIC);

   // Handshake sequencer.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r    <= ST_IDLE;
         cnt_r      <= '0;
         words_r    <= '0;
         req_pend_r <= 1'b0;
         rtr_n_r    <= 1'b1;
         eob_n_r    <= 1'b0;
         rx_data_o  <= '0;
         rx_valid_o <= 1'b0;
         rx_last_o  <= 1'b0;
      end else begin
         if (rx_valid_o && rx_ready_i) begin
            rx_valid_o <= 1'b0;
         end
         unique case (state_r)
            ST_IDLE: begin
               cnt_r <= '0;
               if (mode_i == PBP_MODE_BLOCK) begin
                  eob_n_r <= 1'b1;
                  // Back-pressure: the word is only taken when the user is free.
                  // A rise that meets a busy user is remembered, because the host
                  // holds its request until acknowledged and would otherwise hang.
                  if ((req_rise || req_pend_r) && !rx_valid_o) begin
                     rx_data_o  <= link.parallel_data;
                     rx_valid_o <= 1'b1;
                     rx_last_o  <= (words_r == blk_len - 6'h01);
                     rtr_n_r    <= 1'b0;
                     req_pend_r <= 1'b0;
                     state_r    <= ST_ACK;
                  end else if (req_rise) begin
                     req_pend_r <= 1'b1;
                  end
               end else if (mode_i == PBP_MODE_DOWNLOAD) begin
                  eob_n_r <= 1'b1;
                  if (!rx_valid_o) begin
                     rtr_n_r <= 1'b0;
                     state_r <= ST_WAIT;
                  end
               end
            end
            ST_ACK: begin
               // Hold the acknowledge for the least time in core clock periods.
               if (clm_tick) begin
                  cnt_r <= cnt_r + 1'b1;
               end
               if (cnt_r == CNT_W'(ACK_CLM)) begin
                  rtr_n_r <= 1'b1;
                  cnt_r   <= '0;
                  if (words_r == blk_len - 6'h01) begin
                     words_r <= '0;
                     eob_n_r <= 1'b0;
                     state_r <= ST_EOB;
                  end else begin
                     words_r <= words_r + 6'h01;
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_EOB: begin
               if (clm_tick) begin
                  cnt_r <= cnt_r + 1'b1;
               end
               // Rise again only once the host has dropped its request.
               if (cnt_r >= CNT_W'(EOB_CLM) && !link.host_request) begin
                  eob_n_r <= 1'b1;
                  state_r <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (strb_fall) begin
                  rx_data_o  <= link.parallel_data;
                  rx_valid_o <= 1'b1;
                  rx_last_o  <= 1'b0;
               end
               if (strb_rise) begin
                  rtr_n_r <= 1'b1;
                  cnt_r   <= '0;
                  state_r <= ST_ARM;
               end
            end
            ST_ARM: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r >= CNT_W'(REARM_CYC - 1)) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_OUT: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Output buffer of one byte.
   assign tx_ready_o = ~out_full_r & (mode_i == PBP_MODE_OUTPUT);
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         out_r      <= '0;
         out_full_r <= 1'b0;
         rts_n_r    <= 1'b1;
         oe_r       <= 1'b0;
      end else begin
         if (tx_valid_i && tx_ready_o) begin
            out_r      <= tx_data_i;
            out_full_r <= 1'b1;
            rts_n_r    <= 1'b0;
         end
         if (mode_i == PBP_MODE_OUTPUT && out_full_r && strb_fall) begin
            oe_r <= 1'b1;
         end
         if (oe_r && strb_rise) begin
            oe_r       <= 1'b0;
            out_full_r <= 1'b0;
            rts_n_r    <= 1'b1;
         end
      end
   end

   assign link.ready_to_receive_n = rtr_n_r;
   assign link.ready_to_send_n    = rts_n_r;
   assign link.end_of_block_n     = eob_n_r;
   assign link.dev_data_out       = out_r;
   assign link.dev_data_oe        = oe_r;
endmodule

// ---- hdl/pbp_host.sv ----
`timescale 1ns/1ps
module pbp_host
   import pbp_pkg::*;
#(
   parameter int unsigned STROBE_CYC = 2
) (
   // Clock and reset.
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   // Link.
   pbp_if.host                    link,
   // User side.
   input  wire pbp_mode_e         mode_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic              wr_valid_i,
   output logic                   wr_ready_o,
   output logic [DATA_W-1:0]      rd_data_o,
   output logic                   rd_valid_o
);
   typedef enum logic [3:0] {
      HS_IDLE = 4'h1,
      HS_REQ  = 4'h2,
      HS_LOW  = 4'h4,
      HS_HIGH = 4'h8
   } pbp_hstate_e;

   pbp_hstate_e       st_r;
   logic              req_r;
   logic              strb_n_r;
   logic [DATA_W-1:0] dout_r;
   logic              oe_r;
   logic              seen_ack_r;
   logic [7:0]        cnt_r;

   assign wr_ready_o = (st_r == HS_IDLE) && (
      (mode_i == PBP_MODE_BLOCK && link.end_of_block_n) ||
      (mode_i == PBP_MODE_DOWNLOAD && !link.ready_to_receive_n));

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_r       <= HS_IDLE;
         req_r      <= 1'b0;
         strb_n_r   <= 1'b1;
         dout_r     <= '0;
         oe_r       <= 1'b0;
         seen_ack_r <= 1'b0;
         cnt_r      <= '0;
         rd_data_o  <= '0;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= 1'b0;
         req_r      <= (mode_i == PBP_MODE_OUTPUT) ? 1'b1 : req_r;
         unique case (st_r)
            HS_IDLE: begin
               cnt_r <= '0;
               if (mode_i != PBP_MODE_OUTPUT) begin
                  oe_r <= 1'b0;
               end
               if (mode_i == PBP_MODE_DOWNLOAD) begin
                  req_r <= 1'b0;
               end
               if (wr_valid_i && wr_ready_o) begin
                  dout_r <= wr_data_i;
                  oe_r   <= 1'b1;
                  if (mode_i == PBP_MODE_BLOCK) begin
                     req_r      <= 1'b1;
                     seen_ack_r <= 1'b0;
                     st_r       <= HS_REQ;
                  end else begin
                     strb_n_r <= 1'b0;
                     st_r     <= HS_LOW;
                  end
               end else if (mode_i == PBP_MODE_OUTPUT && !link.ready_to_send_n) begin
                  strb_n_r <= 1'b0;
                  st_r     <= HS_LOW;
               end
            end
            HS_REQ: begin
               if (!link.ready_to_receive_n) begin
                  seen_ack_r <= 1'b1;
               end
               if (seen_ack_r && link.ready_to_receive_n) begin
                  req_r <= 1'b0;
                  oe_r  <= 1'b0;
                  st_r  <= HS_IDLE;
               end
               // Block end seen: drop the request and wait for the rise.
               if (!link.end_of_block_n) begin
                  req_r <= 1'b0;
               end
            end
            HS_LOW: begin
               cnt_r <= cnt_r + 8'h01;
               if (cnt_r == 8'(STROBE_CYC - 1)) begin
                  if (mode_i == PBP_MODE_OUTPUT) begin
                     rd_data_o  <= link.parallel_data;
                     rd_valid_o <= 1'b1;
                  end
                  strb_n_r <= 1'b1;
                  cnt_r    <= '0;
                  st_r     <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               oe_r <= 1'b0;
               // Wait for the device to take back its ready line.
               if (link.ready_to_receive_n && link.ready_to_send_n) begin
                  st_r <= HS_IDLE;
               end
            end
            default: st_r <= HS_IDLE;
         endcase
      end
   end

   assign link.host_request  = req_r;
   assign link.byte_strobe_n = strb_n_r;
   assign link.host_data_out = dout_r;
   assign link.host_data_oe  = oe_r & (mode_i != PBP_MODE_OUTPUT);
endmodule

// ---- tb/pbp_link_asserts.sv ----
`timescale 1ns/1ps
module pbp_link_asserts
   import pbp_pkg::*;
(
   // Clock and reset.
   input wire logic       clk_i,
   input wire logic       reset_i,
   // Link signals and mode.
   input wire pbp_mode_e  mode_i,
   input wire logic       host_request,
   input wire logic       byte_strobe_n,
   input wire logic       ready_to_receive_n,
   input wire logic       ready_to_send_n,
   input wire logic       end_of_block_n,
   input wire logic [7:0] dev_data_out,
   input wire logic       dev_data_oe,
   input wire logic       host_data_oe
);
   logic [7:0] eob_cnt_r;

   // Saturating count of cycles spent in end of block.
   always_ff @(posedge clk_i) begin
      if (reset_i || end_of_block_n) begin
         eob_cnt_r <= 8'h00;
      end else if (eob_cnt_r != 8'hff) begin
         eob_cnt_r <= eob_cnt_r + 8'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence ack_low;
      !ready_to_receive_n [*5];
   endsequence
   sequence rearm_gap;
      ready_to_receive_n [*4];
   endsequence

   a_oe_output_only: assert property (dev_data_oe |-> mode_i == PBP_MODE_OUTPUT)
      else $error("device drives data outside output mode");
   a_oe_after_fall: assert property (mode_i == PBP_MODE_OUTPUT && $fell(byte_strobe_n)
      && !ready_to_send_n |-> ##1 dev_data_oe) else $error("output byte not driven");
   a_oe_release: assert property ($rose(byte_strobe_n) |-> ##[0:1] !dev_data_oe)
      else $error("data bus not released");
   a_send_until_read: assert property (mode_i == PBP_MODE_OUTPUT && $rose(ready_to_send_n)
      |-> $past(dev_data_oe) || $past(dev_data_oe, 2)) else $error("send ready ended early");
   a_ack_after_req: assert property (mode_i == PBP_MODE_BLOCK && $fell(ready_to_receive_n)
      |-> $past(host_request)) else $error("acknowledge without request");
   a_ack_hold_time: assert property (mode_i == PBP_MODE_BLOCK && $fell(ready_to_receive_n)
      |-> ack_low ##[1:3] ready_to_receive_n) else $error("acknowledge length wrong");
   a_host_drop: assert property (mode_i == PBP_MODE_BLOCK && $rose(ready_to_receive_n)
      && host_request |-> ##[1:2] !host_request) else $error("request not dropped");
   a_req_after_eob: assert property (mode_i == PBP_MODE_BLOCK && $rose(host_request)
      |-> end_of_block_n) else $error("request during end of block");
   a_eob_hold: assert property ($rose(end_of_block_n) |-> !host_request
      && (eob_cnt_r < 8'h03 || eob_cnt_r >= EOB_CLM)) else $error("end of block too short");
   a_dl_strobe_in: assert property (mode_i == PBP_MODE_DOWNLOAD && $fell(byte_strobe_n)
      |-> !ready_to_receive_n) else $error("strobe while not ready");
   a_dl_release: assert property (mode_i == PBP_MODE_DOWNLOAD && $rose(byte_strobe_n)
      |-> ##[0:2] ready_to_receive_n) else $error("download cycle not finished");
   a_dl_rearm: assert property (mode_i == PBP_MODE_DOWNLOAD && $rose(ready_to_receive_n)
      |-> rearm_gap) else $error("download re-arm too soon");
   a_req_level: assert property ($fell(byte_strobe_n)
      |-> host_request == (mode_i == PBP_MODE_OUTPUT)) else $error("request level wrong");
   a_one_bus_driver: assert property (!(dev_data_oe && host_data_oe))
      else $error("both ends drive the data bus");
   a_out_byte_stable: assert property (dev_data_oe && $past(dev_data_oe)
      |-> $stable(dev_data_out)) else $error("output byte changed while driven");
endmodule

// ---- tb/parallel_byte_port_handshake_tb.sv ----
`timescale 1ns/1ps
module parallel_byte_port_handshake_tb;
   import pbp_pkg::*;
   logic              clk_i, reset_i, speech_i, rx_ready_i, tx_valid_i, wr_valid_i;
   logic              rx_valid_o, rx_last_o, tx_ready_o, wr_ready_o, rd_valid_o;
   logic              hreq_prev, oe_prev, eob_prev;
   logic [DATA_W-1:0] tx_data_i, wr_data_i, rx_data_o, rd_data_o;
   logic [7:0]        in_q[$];
   logic [7:0]        out_q[$];
   pbp_mode_e         mode_i;
   int                fail_count, samples_checked, rx_cnt, bsz, eob_falls;
   int unsigned       seed_v;

   pbp_if link ();
   pbp_device u_pbp_device (.clk_i(clk_i), .reset_i(reset_i), .link(link), .mode_i(mode_i),
      .speech_i(speech_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
      .rx_last_o(rx_last_o), .rx_ready_i(rx_ready_i), .tx_data_i(tx_data_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o));
   pbp_host u_pbp_host (.clk_i(clk_i), .reset_i(reset_i), .link(link), .mode_i(mode_i),
      .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
   pbp_link_asserts u_pbp_link_asserts (.clk_i(clk_i), .reset_i(reset_i), .mode_i(mode_i),
      .host_request(link.host_request), .byte_strobe_n(link.byte_strobe_n),
      .ready_to_receive_n(link.ready_to_receive_n), .ready_to_send_n(link.ready_to_send_n),
      .end_of_block_n(link.end_of_block_n), .dev_data_out(link.dev_data_out),
      .dev_data_oe(link.dev_data_oe), .host_data_oe(link.host_data_oe));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic timed_out(input int g, input int lim);
      if (g >= lim) begin
         fail_count++;
         complete_run();
      end
   endtask

   task automatic push(input logic out);
      int g;
      @(negedge clk_i);
      if (out) begin
         tx_data_i = 8'($urandom);
         tx_valid_i = 1'b1;
         out_q.push_back(tx_data_i);
      end else begin
         wr_data_i = 8'($urandom);
         wr_valid_i = 1'b1;
         in_q.push_back(wr_data_i);
      end
      for (g = 0; g < 1000; g++) begin
         @(posedge clk_i);
         if ((out ? tx_ready_o : wr_ready_o) === 1'b1) break;
      end
      timed_out(g, 1000);
   endtask

   task automatic run_mode(input pbp_mode_e m, input logic s, input int n);
      int g;
      @(negedge clk_i);
      reset_i = 1'b1;
      mode_i = m;
      speech_i = s;
      repeat (12) @(negedge clk_i);
      reset_i = 1'b0;
      rx_cnt = 0;
      eob_falls = 0;
      bsz = s ? BLOCK_SPEECH : BLOCK_MUSIC;
      for (int i = 0; i < n; i++) push(m == PBP_MODE_OUTPUT);
      @(negedge clk_i);
      wr_valid_i = 1'b0;
      tx_valid_i = 1'b0;
      for (g = 0; g < 4000 && (in_q.size() + out_q.size() != 0 || eob_falls < n / bsz); g++)
         @(negedge clk_i);
      timed_out(g, 4000);
      if (m == PBP_MODE_BLOCK) check(8'(eob_falls), 8'(n / bsz));
   endtask

   // Model side: bytes must leave in the order they were offered.
   always @(posedge clk_i) begin
      if (!reset_i) begin
         if (rx_valid_o === 1'b1 && rx_ready_i) begin
            check(rx_data_o, in_q.size() != 0 ? in_q.pop_front() : 8'hxx);
            if (mode_i == PBP_MODE_BLOCK)
               check({7'h00, rx_last_o}, {7'h00, (rx_cnt % bsz) == bsz - 1});
            rx_cnt++;
         end
         if (link.dev_data_oe === 1'b1 && !oe_prev)
            check(link.parallel_data, out_q.size() != 0 ? out_q[0] : 8'hxx);
         if (rd_valid_o === 1'b1)
            check(rd_data_o, out_q.size() != 0 ? out_q.pop_front() : 8'hxx);
         if (mode_i == PBP_MODE_BLOCK && link.host_request === 1'b1 && !hreq_prev)
            check({7'h00, link.end_of_block_n}, 8'h01);
         if (eob_prev && link.end_of_block_n === 1'b0) eob_falls++;
      end
      hreq_prev <= link.host_request;
      oe_prev <= link.dev_data_oe;
      eob_prev <= link.end_of_block_n;
   end

   // The receiving user stalls now and then.
   always @(negedge clk_i) rx_ready_i <= ($urandom % 4) != 0;

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial begin
      seed_v = $urandom(32'hfcb8d530);
      {reset_i, speech_i, rx_ready_i, tx_valid_i, wr_valid_i} = 5'b10100;
      {tx_data_i, wr_data_i} = 16'h0000;
      mode_i = PBP_MODE_BLOCK;
      fail_count = 0;
      samples_checked = 0;
      run_mode(PBP_MODE_BLOCK, 1'b0, 60);
      run_mode(PBP_MODE_BLOCK, 1'b1, 20);
      run_mode(PBP_MODE_DOWNLOAD, 1'b0, 12);
      run_mode(PBP_MODE_OUTPUT, 1'b0, 12);
      complete_run();
   end
endmodule
